// ### logic/auth_memory_access.sv
// serial register bank for the authentication engine and the 384-byte scratch memory
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - enable bit gates authentication; host clears it last
// R2 - device clears start bit when hash finishes
// R3 - host loads valid command and challenge first
// R4 - memory writes only with write enable set; the engine's digest store writes regardless of it
// R5 - bank select picks lower or upper bank
// R6 - burst past 0xff switches to bank 1
// R7 - scratch memory holds 384 bytes, two banks
// R8 - memory address saturates at 0x17f
// R9 - index gives burst start within bank
// R10 - data port keeps serial register address fixed
// R11 - each data port access advances memory address
// R12 - data port writes and reads current byte
// R13 - read-only identifier names channel variant
// R14 - blocked writes discarded, reads still work
// R15 - host starts with start and enable, waits
// R16 - command 0x35 with identifier, 0x36 without
// R17 - challenge read, digest written from byte zero
// R18 - digest is hash over 512-bit message
module auth_memory_access #(
  parameter int            CHANNELS        = 1,
  parameter logic [7:0]    SINGLE_CODE     = 8'h5a, // arbitrary value
  parameter logic [7:0]    DUAL_CODE       = 8'h5b, // arbitrary value
  parameter logic [159:0]  SECRET          = 160'h0,
  parameter logic [63:0]   UNIQUE_ID       = 64'h0, // arbitrary value
  parameter logic [191:0]  PAD_CONSTANT    = 192'h0
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // serial interface pins
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  // hash engine
  output logic             hash_request_out,
  output logic [511:0]     hash_message_out,
  input  wire logic [255:0] hash_digest_in,
  input  wire logic        hash_done_in,
  // status
  output logic             auth_enable_out,
  output logic             hash_done_out
);

  // only one or two channels have an identifier code
  if (CHANNELS < 1 || CHANNELS > 2) begin : g_channels_check
    $error("CHANNELS must be 1 or 2");
  end

  typedef struct packed {
    logic [2:0]                    sclk_sync;
    logic [2:0]                    cs_sync;
    logic [2:0]                    mosi_sync;
    logic                          sclk_f;
    logic                          cs_n_f;
    logic                          mosi_f;
    logic [2:0]                    bit_count;
    logic [1:0]                    byte_count;
    logic [7:0]                    shift_in;
    logic [7:0]                    shift_out;
    logic [7:0]                    reg_addr;
    logic                          read_mode;
    logic [7:0]                    hash_command;
    logic                          hash_enable;
    logic                          hash_start;
    logic                          write_enable;
    logic                          bank_select;
    logic [7:0]                    scratch_index;
    auth_memory_pkg::engine_state_t engine;
    logic [5:0]                    step;
    logic [159:0]                  challenge;
    logic [255:0]                  digest;
    logic                          hash_request;
    logic                          hash_done;
  } state_t;

  state_t     r;
  state_t     next_r;
  logic [7:0] memory [auth_memory_pkg::MEMORY_BYTES]; // R7
  logic       mem_we;
  logic [8:0] mem_addr;
  logic [7:0] mem_wdata;
  logic       byte_done;
  logic       port_done;

  function automatic logic [8:0] eff_addr(input logic bank, input logic [7:0] index);
    if (bank && index > auth_memory_pkg::BANK1_TOP_INDEX) begin
      return auth_memory_pkg::TOP_ADDRESS; // R8
    end
    return {bank, index}; // R5
  endfunction : eff_addr

  function automatic logic [8:0] advance(input logic bank, input logic [7:0] index);
    if (bank && index >= auth_memory_pkg::BANK1_TOP_INDEX) begin
      return {1'b1, auth_memory_pkg::BANK1_TOP_INDEX}; // R8 R11
    end
    if (index == auth_memory_pkg::BANK0_TOP_INDEX) begin
      return {1'b1, 8'h00}; // R6
    end
    return {bank, 8'(index + 8'h01)}; // R11
  endfunction : advance

  always_comb begin
    logic [7:0] rx;
    logic [8:0] moved;
    rx = '0;
    moved = '0;
    next_r = r;
    next_r.hash_request = 1'b0;
    next_r.hash_done = 1'b0;
    mem_we = 1'b0;
    mem_addr = '0;
    mem_wdata = '0;
    byte_done = 1'b0;
    port_done = 1'b0;
    // pin filter: stage 0 only feeds stage 1
    next_r.sclk_sync = {r.sclk_sync[1:0], spi_sclk_in};
    next_r.cs_sync = {r.cs_sync[1:0], spi_cs_n_in};
    next_r.mosi_sync = {r.mosi_sync[1:0], spi_mosi_in};
    if (r.sclk_sync[1] == r.sclk_sync[2]) begin
      next_r.sclk_f = r.sclk_sync[2];
    end
    if (r.cs_sync[1] == r.cs_sync[2]) begin
      next_r.cs_n_f = r.cs_sync[2];
    end
    if (r.mosi_sync[1] == r.mosi_sync[2]) begin
      next_r.mosi_f = r.mosi_sync[2];
    end

    // hash engine
    if (r.engine != auth_memory_pkg::ENGINE_IDLE && !r.hash_enable) begin
      next_r.engine = auth_memory_pkg::ENGINE_IDLE; // R1
      next_r.hash_start = 1'b0;
    end else begin
      unique case (r.engine)
        auth_memory_pkg::ENGINE_IDLE: begin
          if (r.hash_start && r.hash_enable) begin
            next_r.step = '0;
            // reserved codes finish at once and leave memory alone
            if (r.hash_command == auth_memory_pkg::CMD_WITH_ID ||
                r.hash_command == auth_memory_pkg::CMD_WITHOUT_ID) begin
              next_r.engine = auth_memory_pkg::ENGINE_GATHER; // R16
            end else begin
              next_r.engine = auth_memory_pkg::ENGINE_FINISH;
            end
          end
        end
        auth_memory_pkg::ENGINE_GATHER: begin
          next_r.challenge = {r.challenge[151:0], memory[{3'b000, r.step}]}; // R17
          next_r.step = 6'(r.step + 6'h01);
          if (r.step == 6'(auth_memory_pkg::CHALLENGE_BYTES - 6'h01)) begin
            next_r.engine = auth_memory_pkg::ENGINE_REQUEST;
          end
        end
        auth_memory_pkg::ENGINE_REQUEST: begin
          next_r.hash_request = 1'b1; // R18
          next_r.engine = auth_memory_pkg::ENGINE_WAIT;
        end
        auth_memory_pkg::ENGINE_WAIT: begin
          if (hash_done_in) begin
            next_r.digest = hash_digest_in;
            next_r.step = '0;
            next_r.engine = auth_memory_pkg::ENGINE_STORE;
          end
        end
        auth_memory_pkg::ENGINE_STORE: begin
          mem_we = 1'b1; // R17
          mem_addr = {3'b000, r.step};
          mem_wdata = r.digest[255:248];
          next_r.digest = {r.digest[247:0], 8'h00};
          next_r.step = 6'(r.step + 6'h01);
          if (r.step == 6'(auth_memory_pkg::DIGEST_BYTES - 6'h01)) begin
            next_r.engine = auth_memory_pkg::ENGINE_FINISH;
          end
        end
        auth_memory_pkg::ENGINE_FINISH: begin
          next_r.hash_start = 1'b0; // R2
          next_r.hash_done = 1'b1;
          next_r.engine = auth_memory_pkg::ENGINE_IDLE;
        end
      endcase
    end

    // serial frame: address byte, direction byte, then data bytes
    if (next_r.cs_n_f) begin
      next_r.bit_count = '0;
      next_r.byte_count = '0;
    end else if (next_r.sclk_f && !r.sclk_f) begin
      rx = {r.shift_in[6:0], next_r.mosi_f};
      next_r.shift_in = rx;
      next_r.bit_count = 3'(r.bit_count + 3'h1);
      if (r.bit_count == 3'h7) begin
        byte_done = 1'b1;
        unique case (r.byte_count)
          2'h0: begin
            next_r.reg_addr = rx;
            next_r.byte_count = 2'h1;
          end
          2'h1: begin
            next_r.read_mode = (rx == auth_memory_pkg::SPI_READ_CODE);
            next_r.byte_count = 2'h2;
          end
          default: begin
            if (!r.read_mode) begin
              unique case (r.reg_addr)
                auth_memory_pkg::HASH_COMMAND_ADDR: next_r.hash_command = rx;
                auth_memory_pkg::HASH_CONTROL_ADDR: begin
                  next_r.hash_start = rx[auth_memory_pkg::HASH_START_BIT];
                  next_r.hash_enable = rx[auth_memory_pkg::HASH_ENABLE_BIT]; // R1
                end
                auth_memory_pkg::MEMORY_CONTROL_ADDR: begin
                  next_r.bank_select = rx[auth_memory_pkg::BANK_SELECT_BIT]; // R5
                  next_r.write_enable = rx[auth_memory_pkg::WRITE_ENABLE_BIT];
                end
                auth_memory_pkg::MEMORY_INDEX_ADDR: next_r.scratch_index = rx; // R9
                auth_memory_pkg::MEMORY_DATA_ADDR: begin
                  // engine owns the write port while it runs
                  if (r.write_enable && r.engine == auth_memory_pkg::ENGINE_IDLE) begin
                    mem_we = 1'b1; // R4 R12 R14
                    mem_addr = eff_addr(r.bank_select, r.scratch_index);
                    mem_wdata = rx;
                  end
                end
                default: begin
                end
              endcase
            end
            if (r.reg_addr == auth_memory_pkg::MEMORY_DATA_ADDR) begin
              port_done = 1'b1;
              moved = advance(next_r.bank_select, next_r.scratch_index); // R11
              next_r.bank_select = moved[8];
              next_r.scratch_index = moved[7:0];
            end else begin
              next_r.reg_addr = 8'(r.reg_addr + 8'h01); // R10
            end
          end
        endcase
        if (next_r.read_mode && r.byte_count != 2'h0) begin
          unique case (next_r.reg_addr)
            auth_memory_pkg::HASH_COMMAND_ADDR: next_r.shift_out = next_r.hash_command;
            auth_memory_pkg::HASH_CONTROL_ADDR: next_r.shift_out =
              {6'h00, next_r.hash_enable, next_r.hash_start};
            auth_memory_pkg::MEMORY_CONTROL_ADDR: next_r.shift_out =
              {6'h00, next_r.write_enable, next_r.bank_select};
            auth_memory_pkg::MEMORY_INDEX_ADDR: next_r.shift_out = next_r.scratch_index;
            auth_memory_pkg::MEMORY_DATA_ADDR: next_r.shift_out =
              memory[eff_addr(next_r.bank_select, next_r.scratch_index)]; // R12
            auth_memory_pkg::DEVICE_ID_ADDR: next_r.shift_out =
              (CHANNELS == 2) ? DUAL_CODE : SINGLE_CODE; // R13
            default: next_r.shift_out = auth_memory_pkg::REGISTER_RESET;
          endcase
        end
      end
    end else if (!next_r.sclk_f && r.sclk_f && r.bit_count != 3'h0) begin
      // the first bit of each byte is already on the pin after the load
      next_r.shift_out = {r.shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.cs_sync <= 3'b111;
      r.cs_n_f <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // contents are not cleared by reset
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      memory[mem_addr] <= mem_wdata;
    end
  end

  assign spi_miso_out = r.shift_out[7];
  assign hash_request_out = r.hash_request;
  assign hash_done_out = r.hash_done;
  assign auth_enable_out = r.hash_enable;
  assign hash_message_out = (r.hash_command == auth_memory_pkg::CMD_WITH_ID) ?
    {SECRET, r.challenge, UNIQUE_ID, PAD_CONSTANT[127:0]} :
    {SECRET, r.challenge, PAD_CONSTANT}; // R16 R18

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence finish_seq;
    r.engine == auth_memory_pkg::ENGINE_FINISH;
  endsequence
  sequence cleared_seq;
    r.engine == auth_memory_pkg::ENGINE_IDLE && !r.hash_start && hash_done_out;
  endsequence

  start_clear_a: assert property (finish_seq |=> cleared_seq) // R2
    else $error("start bit not cleared after hash");
  enable_abort_a: assert property (
    (!r.hash_enable && r.engine != auth_memory_pkg::ENGINE_IDLE)
      |=> r.engine == auth_memory_pkg::ENGINE_IDLE) // R1
    else $error("engine kept running without enable");
  write_block_a: assert property (
    (mem_we && r.engine == auth_memory_pkg::ENGINE_IDLE) |-> r.write_enable) // R4
    else $error("memory written while writes disabled");
  bank_roll_a: assert property (
    (port_done && !r.bank_select && r.scratch_index == 8'hff)
      |=> r.bank_select && r.scratch_index == 8'h00) // R6
    else $error("burst did not move to upper bank");
  address_hold_a: assert property (
    (port_done && r.bank_select && r.scratch_index == 8'h7f)
      |=> r.bank_select && r.scratch_index == 8'h7f) // R8
    else $error("memory address passed its top");
  port_fixed_a: assert property (port_done |=> r.reg_addr == 8'hf4) // R10
    else $error("data port burst moved register address");
  index_step_a: assert property (
    (port_done && r.scratch_index < 8'h7f)
      |=> r.scratch_index == 8'($past(r.scratch_index) + 8'h01)) // R11
    else $error("memory address did not advance");
  ident_read_a: assert property (
    (byte_done && next_r.read_mode && r.byte_count != 2'h0 && next_r.reg_addr == 8'hff)
      |=> r.shift_out == ((CHANNELS == 2) ? DUAL_CODE : SINGLE_CODE)) // R13
    else $error("identifier read returned wrong code");
  gather_span_a: assert property (
    (r.engine == auth_memory_pkg::ENGINE_GATHER) |-> r.step < 6'h14) // R17
    else $error("challenge gather overran twenty bytes");
  request_wait_a: assert property (
    hash_request_out |-> r.engine == auth_memory_pkg::ENGINE_WAIT ##1 !hash_request_out) // R18
    else $error("hash request not a single pulse");

endmodule : auth_memory_access

`default_nettype wire

// ### logic/auth_memory_pkg.sv
// constants and types shared by the authentication and scratch memory register bank
package auth_memory_pkg;
  // register addresses on the serial interface
  localparam logic [7:0] HASH_COMMAND_ADDR   = 8'hf0;
  localparam logic [7:0] HASH_CONTROL_ADDR   = 8'hf1;
  localparam logic [7:0] MEMORY_CONTROL_ADDR = 8'hf2;
  localparam logic [7:0] MEMORY_INDEX_ADDR   = 8'hf3;
  localparam logic [7:0] MEMORY_DATA_ADDR    = 8'hf4;
  localparam logic [7:0] DEVICE_ID_ADDR      = 8'hff;
  // field positions
  localparam int HASH_START_BIT   = 0;
  localparam int HASH_ENABLE_BIT  = 1;
  localparam int BANK_SELECT_BIT  = 0;
  localparam int WRITE_ENABLE_BIT = 1;
  // values after reset
  localparam logic [7:0] REGISTER_RESET = 8'h00;
  // hash command codes
  localparam logic [7:0] CMD_WITH_ID    = 8'h35;
  localparam logic [7:0] CMD_WITHOUT_ID = 8'h36;
  // second byte of a serial frame
  localparam logic [7:0] SPI_READ_CODE  = 8'h80;
  // scratch memory geometry
  localparam int         MEMORY_BYTES    = 384;
  localparam logic [8:0] TOP_ADDRESS     = 9'h17f;
  localparam logic [7:0] BANK0_TOP_INDEX = 8'hff;
  localparam logic [7:0] BANK1_TOP_INDEX = 8'h7f;
  // byte counts of the hash transfer
  localparam logic [5:0] CHALLENGE_BYTES = 6'h14;
  localparam logic [5:0] DIGEST_BYTES    = 6'h20;

  typedef enum {
    ENGINE_IDLE,
    ENGINE_GATHER,
    ENGINE_REQUEST,
    ENGINE_WAIT,
    ENGINE_STORE,
    ENGINE_FINISH
  } engine_state_t;
endpackage : auth_memory_pkg

// ### tb/spi_host_model.sv
// serial host model that drives the register bank pins in mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // clock
  input  wire logic       clk_in,
  // serial pins
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic            mosi_out,
  input  wire logic       miso_in,
  // returned bytes
  output logic            rd_valid_out,
  output logic [7:0]      rd_byte_out
);
  initial begin
    sclk_out     = 1'b0;
    cs_n_out     = 1'b1;
    mosi_out     = 1'b0;
    rd_valid_out = 1'b0;
    rd_byte_out  = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_clk

  // eight clocks a phase keeps each phase above the pin filter's minimum
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      mosi_out <= tx[i];
      wait_clk(8);
      rx[i] = miso_in;
      sclk_out <= 1'b1;
      wait_clk(8);
      sclk_out <= 1'b0;
    end
  endtask : shift_byte

  task automatic frame(input logic [7:0] addr, input logic rd, input logic [7:0] data[$]);
    logic [7:0] rx;
    cs_n_out <= 1'b0;
    wait_clk(8);
    shift_byte(addr, rx);
    shift_byte(rd ? 8'h80 : 8'h00, rx);
    foreach (data[i]) begin
      shift_byte(data[i], rx);
      if (rd) begin
        rd_byte_out  <= rx;
        rd_valid_out <= 1'b1;
        wait_clk(1);
        rd_valid_out <= 1'b0;
      end
    end
    wait_clk(8);
    cs_n_out <= 1'b1;
    // released line shows the inverse so a stale value is never read as good
    mosi_out <= ~mosi_out;
    wait_clk(8);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// ### tb/auth_memory_access_tb.sv
// self-checking bench for the authentication and scratch memory register bank
`timescale 1ns/1ps
`default_nettype none
module auth_memory_access_tb;
  localparam logic [7:0]   ID_CODE = 8'h3c; // arbitrary value
  localparam logic [159:0] SECRET  = 160'h1234_5678_9abc;
  localparam logic [63:0]  UID     = 64'h0123_4567_89ab_cdef; // arbitrary value
  localparam logic [191:0] PAD     = {64'hfedc_ba98_7654_3210, 128'h0};
  logic         clk, rst, sclk, cs_n, mosi, miso, req, hdone_in, en, hdone, rd_valid, stall;
  logic [511:0] msg;
  logic [255:0] digest;
  logic [159:0] chal;
  logic [7:0]   rd_byte, cur_cmd, a, b, c;
  logic [7:0]   exp_q[$], tx_q[$], ex_q[$];
  logic [7:0]   cmds[3];
  logic [31:0]  seed = 32'hf0d5;
  int           num_errors = 0, checked = 0, done_cnt = 0, hold_cnt = 0, n;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  auth_memory_access #(.SINGLE_CODE(ID_CODE), .SECRET(SECRET), .UNIQUE_ID(UID),
    .PAD_CONSTANT(PAD)) dut (.clk_in(clk), .rst_in(rst), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .hash_request_out(req),
    .hash_message_out(msg), .hash_digest_in(digest), .hash_done_in(hdone_in),
    .auth_enable_out(en), .hash_done_out(hdone));

  spi_host_model host (.clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_vec(input logic [159:0] got, input logic [159:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: hash message field %h expected %h", $time, got, exp);
    end
  endtask : cmp_vec

  task automatic wr_regs(input logic [7:0] addr, input logic [7:0] d[$]);
    host.frame(addr, 1'b0, d);
  endtask : wr_regs

  task automatic rd_regs(input logic [7:0] addr, input logic [7:0] e[$]);
    foreach (e[i]) exp_q.push_back(e[i]);
    host.frame(addr, 1'b1, e);
  endtask : rd_regs

  task automatic report_and_stop();
    num_errors += exp_q.size();
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // every data byte the host shifts in during a read frame is matched against the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) cmp_byte(rd_byte, exp_q.pop_front());
    if (hdone === 1'b1) done_cnt <= done_cnt + 1;
  end

  // hash engine stand-in answers a request some cycles later
  always @(posedge clk) begin
    hdone_in <= (hold_cnt == 1);
    if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
    if (req === 1'b1) begin
      if (!stall) hold_cnt <= 6;
      cmp_byte({7'h0, cur_cmd != 8'h00}, 8'h01);
      cmp_vec(msg[511:352], SECRET);
      cmp_vec(msg[351:192], chal);
      cmp_vec({96'h0, msg[191:128]}, {96'h0, cur_cmd == 8'h35 ? UID : PAD[191:128]});
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    stall = 1'b0;
    digest = '0;
    chal = '0;
    cur_cmd = 8'h00;
    cmds = '{auth_memory_pkg::CMD_WITH_ID, auth_memory_pkg::CMD_WITHOUT_ID, 8'h00};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    rd_regs(auth_memory_pkg::HASH_COMMAND_ADDR, '{8'h00, 8'h00, 8'h00, 8'h00});
    wr_regs(8'hff, '{8'h00});
    rd_regs(8'hff, '{ID_CODE});
    rd_regs(8'he0, '{8'h00});
    a = rnd();
    b = rnd();
    c = rnd();
    wr_regs(8'hf2, '{8'h02, 8'hfe});
    wr_regs(8'hf4, '{a, b, c});
    rd_regs(8'hf2, '{8'h03, 8'h01});
    wr_regs(8'hf2, '{8'h00, 8'hfe});
    wr_regs(8'hf4, '{~a, ~b});
    wr_regs(8'hf2, '{8'h00, 8'hfe});
    rd_regs(8'hf4, '{a, b, c});
    wr_regs(8'hf2, '{8'h03, 8'h7e});
    wr_regs(8'hf4, '{a, b, c});
    wr_regs(8'hf3, '{8'h7e});
    rd_regs(8'hf4, '{a, c, c});
    foreach (cmds[k]) begin
      cur_cmd = cmds[k];
      tx_q.delete();
      ex_q.delete();
      for (int i = 0; i < 32; i++) digest[255 - 8 * i -: 8] <= rnd();
      for (int i = 0; i < 20; i++) begin
        tx_q.push_back(rnd());
        chal[159 - 8 * i -: 8] = tx_q[i];
      end
      wr_regs(8'hf2, '{8'h02, 8'h00});
      wr_regs(8'hf4, tx_q);
      wr_regs(auth_memory_pkg::HASH_COMMAND_ADDR, '{cur_cmd});
      n = done_cnt;
      wr_regs(auth_memory_pkg::HASH_CONTROL_ADDR, '{8'h03});
      for (int w = 0; w < 3000 && done_cnt == n; w++) @(posedge clk);
      cmp_byte(done_cnt[7:0], n[7:0] + 8'h01);
      cmp_byte({7'h0, en}, 8'h01);
      rd_regs(auth_memory_pkg::HASH_CONTROL_ADDR, '{8'h02});
      for (int i = 0; i < 20; i++) ex_q.push_back(k < 2 ? digest[255 - 8 * i -: 8] : tx_q[i]);
      wr_regs(8'hf3, '{8'h00});
      rd_regs(8'hf4, ex_q);
      wr_regs(auth_memory_pkg::HASH_CONTROL_ADDR, '{8'h00});
      cmp_byte({7'h0, en}, 8'h00);
    end
    // a silent hash unit leaves the engine waiting; clearing enable must stop it
    stall = 1'b1;
    cur_cmd = auth_memory_pkg::CMD_WITH_ID;
    wr_regs(auth_memory_pkg::HASH_COMMAND_ADDR, '{cur_cmd});
    n = done_cnt;
    wr_regs(auth_memory_pkg::HASH_CONTROL_ADDR, '{8'h03});
    wr_regs(auth_memory_pkg::HASH_CONTROL_ADDR, '{8'h00});
    rd_regs(auth_memory_pkg::HASH_CONTROL_ADDR, '{8'h00});
    cmp_byte(done_cnt[7:0], n[7:0]);
    report_and_stop();
  end
endmodule : auth_memory_access_tb
`default_nettype wire
